// File: include/chgrm_pkg.sv
package chgrm_pkg;

  // Register offsets, as the host addresses them.
  localparam logic [3:0] ADDR_STATE = 4'h0;
  localparam logic [3:0] ADDR_CAUSE1 = 4'h1;
  localparam logic [3:0] ADDR_CAUSE2 = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_RSVD = 4'h4;
  localparam logic [3:0] ADDR_CMD = 4'h5;
  localparam logic [3:0] ADDR_MASK1 = 4'h6;
  localparam logic [3:0] ADDR_MASK2 = 4'h7;
  localparam logic [3:0] ADDR_CFG1 = 4'h8;
  localparam logic [3:0] ADDR_CFG2 = 4'h9;
  localparam logic [3:0] ADDR_VOUT_HI = 4'ha;
  localparam logic [3:0] ADDR_VOUT_LO = 4'hb;
  localparam logic [3:0] ADDR_CURRENT_LIMIT_CODE = 4'hc;
  localparam logic [3:0] ADDR_AUX = 4'hd;
  localparam logic [3:0] ADDR_CFG4 = 4'he;
  localparam logic [3:0] ADDR_CFG5 = 4'hf;

  // The programmable bytes 0x06 to 0x0F live in one small memory.
  localparam int CFG_COUNT = 10;
  localparam logic [CFG_COUNT-1:0][7:0] CFG_DEFAULTS = {
    8'h9e, 8'h23, 8'h30, 8'hff, 8'h10, 8'h32, 8'hf3, 8'h28, 8'h00, 8'h00};
  localparam logic [CFG_COUNT-1:0][7:0] CFG_WMASK = {
    8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hbd};

  // Hard-coded reset values and implemented-bit masks of the low registers.
  localparam logic [7:0] RST_CMD = 8'h00;
  localparam logic [7:0] STATE_USED = 8'h0f;
  localparam logic [7:0] CAUSE1_USED = 8'hbd;
  localparam logic [7:0] CAUSE2_USED = 8'h7f;
  localparam logic [7:0] STATUS_USED = 8'hfc;
  localparam logic [7:0] CMD_STORED = 8'h01;

  // Field positions.
  localparam int CMD_MAIN_EN_BIT = 0;
  localparam int CMD_LOAD_VOUT_BIT = 1;
  localparam int CFG1_MASK_ALL_BIT = 5;
  localparam int VOUT_LO_MSB = 7;
  localparam int VOUT_LO_LSB = 5;
  localparam int VOUT_WIDTH = 11;
  localparam int AUX_WIDTH = 6;
  localparam int C1_CCCV_BIT = 7;
  localparam int C1_SYNC_BIT = 5;
  localparam int C1_FREQ_BIT = 4;
  localparam int C1_THARD_BIT = 3;
  localparam int C1_TSOFT_BIT = 2;
  localparam int C1_OVLO_BIT = 0;

  // Wait in the error position before an automatic retry.
  localparam int ERR_WAIT_MS = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ERR_WAIT_CYCLES = ERR_WAIT_MS * 1000000 / CLK_PERIOD_NS;

  // Control state machine positions.
  typedef enum logic [3:0] {
    ST_NO_POWER = 4'b0000,
    ST_BIAS_INIT = 4'b0001,
    ST_BIAS_RESET = 4'b0010,
    ST_BIAS_ADDR = 4'b0011,
    ST_BIAS_RAMP = 4'b0100,
    ST_BIAS_FREQ = 4'b0101,
    ST_FREQ_LOOP = 4'b0110,
    ST_BIAS_READY = 4'b0111,
    ST_MAIN_EN = 4'b1000,
    ST_MAIN_RAMP = 4'b1001,
    ST_MAIN_ON = 4'b1010,
    ST_MAIN_SHDN = 4'b1011,
    ST_MAIN_ERR = 4'b1100
  } chgrm_state_t;

  // One register access from the serial protocol engine.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } chgrm_req_t;

  // Analog conditions that steer the control state machine.
  typedef struct packed {
    logic power_input_supply_ok;
    logic bias_good;
    logic bias_fault;
    logic freq_res_ok;
    logic main_pg;
    logic main_off;
    logic main_fault;
  } chgrm_cond_t;

  // Protection conditions, each high while present.
  typedef struct packed {
    logic cc_mode;
    logic sync_out_of_range;
    logic freq_res_out_of_range;
    logic hard_thermal_shutdown;
    logic soft_thermal_shutdown;
    logic input_overvoltage;
    logic main_overcurrent;
    logic output_overvoltage;
    logic output_undervoltage;
    logic aux_undervoltage;
    logic bias_overcurrent;
    logic bias_overvoltage;
    logic bias_undervoltage;
  } chgrm_prot_t;

endpackage : chgrm_pkg

// File: rtl/chgrm_cfg_mem.sv
module chgrm_cfg_mem
  import chgrm_pkg::*;
#(
  parameter int DEPTH = CFG_COUNT,
  parameter logic [DEPTH-1:0][7:0] DEFAULTS = CFG_DEFAULTS,
  parameter logic [DEPTH-1:0][7:0] WMASK = CFG_WMASK
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Write port.
  input wire logic wr_en_i,
  input wire logic [3:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // Read port, data one cycle later.
  input wire logic [3:0] raddr_i,
  output logic [7:0] rd_data_o,
  // Every byte, for the logic that uses them.
  output logic [DEPTH-1:0][7:0] bytes_o
);

  // The index is four bits wide.
  initial begin
    if (DEPTH < 1 || DEPTH > 16) begin
      $error("chgrm_cfg_mem: DEPTH must be 1 to 16");
    end
  end

  logic [DEPTH-1:0][7:0] mem_q;
  logic raddr_ok;

  assign raddr_ok = 32'(raddr_i) < DEPTH;
  assign bytes_o = mem_q;

  // Each byte reloads its programmed default and keeps only implemented bits.
  for (genvar i = 0; i < DEPTH; i++) begin : g_byte
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        mem_q[i] <= DEFAULTS[i] & WMASK[i];
      end else if (wr_en_i && 32'(waddr_i) == i) begin
        mem_q[i] <= wdata_i & WMASK[i];
      end
    end
  end

  // Registered read; an index past the end reads zero.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= raddr_ok ? mem_q[raddr_i] : 8'h00;
    end
  end

endmodule : chgrm_cfg_mem

// File: rtl/chgrm_regbank.sv
// Function
// - State position in register zero, low nibble.
// - Supply phase state codes 0000 to 0111.
// - Main converter state codes 1000 to 1100.
// - Transit codes 1, 3, 5, 8 never dwell.
// - Two read-only interrupt cause bytes.
// - Reading a cause byte clears it.
// - Bits whose condition persists stay set.
// - Cause 1 bit 7 on CC/CV change.
// - Cause 1 bit 5 on sync clock range.
// - Cause 1 bit 4 on frequency resistor range.
// - Cause 1 bits 3, 2 on thermal shutdown.
// - Cause 1 bit 0 on input overvoltage.
// - Command byte write triggers device actions.
// - Two mask bytes reset zero, paired bitwise.
// - Eleven-bit output voltage split over 0x0A, 0x0B.
// - Current limit byte at 0x0C, default 0xff.
// - Six-bit aux regulator code, default 0x30.
// - Remaining configuration reset values as listed.
// - Bytes 0x06 to 0x0F factory programmable.
// - Set mask bit blocks that interrupt.
// - Mask-all bit forces every mask bit.
module chgrm_regbank
  import chgrm_pkg::*;
#(
  parameter int ERR_WAIT = ERR_WAIT_CYCLES,
  parameter logic [CFG_COUNT-1:0][7:0] FACTORY_DEFAULTS = CFG_DEFAULTS
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register access from the serial protocol engine.
  input wire chgrm_req_t req_i,
  output logic [7:0] rd_data_o,
  // Analog state and protection inputs.
  input wire chgrm_cond_t cond_i,
  input wire chgrm_prot_t prot_i,
  input wire logic [7:0] status_flags_i,
  // Interrupt and control outputs.
  output logic irq_o,
  output logic main_enable_o,
  output logic [3:0] state_o,
  output logic [VOUT_WIDTH-1:0] output_voltage_code_o,
  output logic [7:0] current_limit_code_o,
  output logic [AUX_WIDTH-1:0] aux_regulator_voltage_o,
  output logic [7:0] config_byte_1_o,
  output logic [7:0] config_byte_2_o,
  output logic [7:0] config_byte_4_o,
  output logic [7:0] config_byte_5_o
);

  // The wait counter is 24 bits wide.
  initial begin
    if (ERR_WAIT < 1 || ERR_WAIT > 16777215) begin
      $error("chgrm_regbank: ERR_WAIT must be 1 to 16777215");
    end
  end

  chgrm_state_t state_q, state_d;
  logic [23:0] wait_q;
  logic [7:0] cause1_q, cause2_q, cmd_q, low_rd_q, prot_pin_q;
  logic [7:0] cond1, cond2, mask1_eff, mask2_eff, low_rd;
  logic [CFG_COUNT-1:0][7:0] cfg;
  logic [7:0] mem_rd;
  logic cc_mode_q, mem_sel_q, irq_q, irq_d;
  logic [VOUT_WIDTH-1:0] vout_q;
  logic wr_cmd, wr_cfg, rd_c1, rd_c2, load_vout, in_mem, cccv_flip, wait_done;

  // Access decode.
  assign in_mem = req_i.addr >= ADDR_MASK1;
  assign wr_cmd = req_i.wr && req_i.addr == ADDR_CMD;
  assign wr_cfg = req_i.wr && in_mem;
  assign rd_c1 = req_i.rd && req_i.addr == ADDR_CAUSE1;
  assign rd_c2 = req_i.rd && req_i.addr == ADDR_CAUSE2;
  assign load_vout = wr_cmd && req_i.wdata[CMD_LOAD_VOUT_BIT];

  // Configuration bytes 0x06 to 0x0F with their programmed defaults.
  chgrm_cfg_mem #(
    .DEPTH(CFG_COUNT),
    .DEFAULTS(FACTORY_DEFAULTS),
    .WMASK(CFG_WMASK)
  ) u_cfg (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .wr_en_i(wr_cfg),
    .waddr_i(req_i.addr - ADDR_MASK1),
    .wdata_i(req_i.wdata),
    .raddr_i(req_i.addr - ADDR_MASK1),
    .rd_data_o(mem_rd),
    .bytes_o(cfg)
  );

  // Named views of the stored bytes.
  assign config_byte_1_o = cfg[ADDR_CFG1 - ADDR_MASK1];
  assign config_byte_2_o = cfg[ADDR_CFG2 - ADDR_MASK1];
  assign current_limit_code_o = cfg[ADDR_CURRENT_LIMIT_CODE - ADDR_MASK1];
  assign aux_regulator_voltage_o = cfg[ADDR_AUX - ADDR_MASK1][AUX_WIDTH-1:0];
  assign config_byte_4_o = cfg[ADDR_CFG4 - ADDR_MASK1];
  assign config_byte_5_o = cfg[ADDR_CFG5 - ADDR_MASK1];

  // The mask-all bit overrides both stored mask bytes.
  assign mask1_eff = cfg[ADDR_MASK1 - ADDR_MASK1]
                   | {8{config_byte_1_o[CFG1_MASK_ALL_BIT]}};
  assign mask2_eff = cfg[ADDR_MASK2 - ADDR_MASK1]
                   | {8{config_byte_1_o[CFG1_MASK_ALL_BIT]}};

  // A mode change is a one-cycle event; the others are levels.
  assign cccv_flip = prot_i.cc_mode != cc_mode_q;
  always_comb begin
    cond1 = 8'h00;
    cond1[C1_CCCV_BIT] = cccv_flip;
    cond1[C1_SYNC_BIT] = prot_i.sync_out_of_range;
    cond1[C1_FREQ_BIT] = prot_i.freq_res_out_of_range;
    cond1[C1_THARD_BIT] = prot_i.hard_thermal_shutdown;
    cond1[C1_TSOFT_BIT] = prot_i.soft_thermal_shutdown;
    cond1[C1_OVLO_BIT] = prot_i.input_overvoltage;
  end
  assign cond2 = {1'b0, prot_i.main_overcurrent, prot_i.output_overvoltage,
                  prot_i.output_undervoltage, prot_i.aux_undervoltage,
                  prot_i.bias_overcurrent, prot_i.bias_overvoltage,
                  prot_i.bias_undervoltage};

  // Cause bits: a present condition sets, a read clears only resolved bits.
  for (genvar b = 0; b < 8; b++) begin : g_cause
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        cause1_q[b] <= 1'b0;
        cause2_q[b] <= 1'b0;
      end else begin
        cause1_q[b] <= CAUSE1_USED[b] & (cond1[b] | (cause1_q[b] & ~rd_c1));
        cause2_q[b] <= CAUSE2_USED[b] & (cond2[b] | (cause2_q[b] & ~rd_c2));
      end
    end
  end

  // Mode history, loaded through reset so a mode held across reset is no change.
  always_ff @(posedge clk_sys_i) begin
    cc_mode_q <= prot_i.cc_mode;
  end

  // Only the enable bit is stored; the load bit is a pulse and reads zero.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cmd_q <= RST_CMD;
    end else if (wr_cmd) begin
      cmd_q <= req_i.wdata & CMD_STORED;
    end
  end
  assign main_enable_o = cmd_q[CMD_MAIN_EN_BIT];

  // The voltage code takes effect only on a load command.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      vout_q <= {FACTORY_DEFAULTS[ADDR_VOUT_HI - ADDR_MASK1],
                 FACTORY_DEFAULTS[ADDR_VOUT_LO - ADDR_MASK1][VOUT_LO_MSB:VOUT_LO_LSB]};
    end else if (load_vout) begin
      vout_q <= {cfg[ADDR_VOUT_HI - ADDR_MASK1],
                 cfg[ADDR_VOUT_LO - ADDR_MASK1][VOUT_LO_MSB:VOUT_LO_LSB]};
    end
  end
  assign output_voltage_code_o = vout_q;

  // Interrupt: any unmasked cause bit raises the output.
  assign irq_d = |(cause1_q & ~mask1_eff) | |(cause2_q & ~mask2_eff);
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end
  assign irq_o = irq_q;

  // Error retry timer.
  assign wait_done = wait_q == 24'(ERR_WAIT - 1);
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || state_q != ST_MAIN_ERR) begin
      wait_q <= 24'h000000;
    end else if (!wait_done) begin
      wait_q <= wait_q + 24'h000001;
    end
  end

  // Control sequencer; transit positions always leave after one cycle.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_NO_POWER:   if (cond_i.power_input_supply_ok) state_d = ST_BIAS_INIT;
      ST_BIAS_INIT:  state_d = ST_BIAS_ADDR;
      ST_BIAS_RESET: state_d = ST_BIAS_INIT;
      ST_BIAS_ADDR:  state_d = ST_BIAS_RAMP;
      ST_BIAS_RAMP:  if (cond_i.bias_good) state_d = ST_BIAS_FREQ;
      ST_BIAS_FREQ:  state_d = cond_i.freq_res_ok ? ST_BIAS_READY : ST_FREQ_LOOP;
      ST_FREQ_LOOP:  if (cond_i.freq_res_ok) state_d = ST_BIAS_READY;
      ST_BIAS_READY: if (main_enable_o) state_d = ST_MAIN_EN;
      ST_MAIN_EN:    state_d = ST_MAIN_RAMP;
      ST_MAIN_RAMP:  if (cond_i.main_pg) state_d = ST_MAIN_ON;
      ST_MAIN_ON:    if (!main_enable_o) state_d = ST_MAIN_SHDN;
      ST_MAIN_SHDN:  if (cond_i.main_off) state_d = ST_BIAS_READY;
      ST_MAIN_ERR:   if (wait_done) state_d = ST_BIAS_READY;
      default:       state_d = ST_NO_POWER;
    endcase
    if ((state_q == ST_MAIN_RAMP || state_q == ST_MAIN_ON) && cond_i.main_fault) begin
      state_d = ST_MAIN_ERR;
    end
    if (state_q >= ST_BIAS_RAMP && cond_i.bias_fault) begin
      state_d = ST_BIAS_RESET;
    end
    if (!cond_i.power_input_supply_ok) begin
      state_d = ST_NO_POWER;
    end
  end

  // State register.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= ST_NO_POWER;
    end else begin
      state_q <= state_d;
    end
  end
  assign state_o = state_q;

  // Read data of the low registers; reserved and unused bits read zero.
  always_comb begin
    unique case (req_i.addr)
      ADDR_STATE:  low_rd = {4'h0, state_q};
      ADDR_CAUSE1: low_rd = cause1_q;
      ADDR_CAUSE2: low_rd = cause2_q;
      ADDR_STATUS: low_rd = status_flags_i & STATUS_USED;
      ADDR_CMD:    low_rd = cmd_q;
      default:     low_rd = 8'h00;
    endcase
  end

  // Read pipeline; the memory answers in the same cycle as these flops.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      low_rd_q <= 8'h00;
      mem_sel_q <= 1'b0;
    end else begin
      low_rd_q <= low_rd;
      mem_sel_q <= in_mem;
    end
  end
  assign rd_data_o = mem_sel_q ? mem_rd : low_rd_q;

  // Helper: protection levels of byte one one cycle back.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      prot_pin_q <= 8'h00;
    end else begin
      prot_pin_q <= cond1;
    end
  end

  // A read request at a given address.
  sequence s_read(logic [3:0] a);
    req_i.rd && req_i.addr == a;
  endsequence

  property p_state_nibble;
    @(posedge clk_sys_i) disable iff (rst_i)
      s_read(ADDR_STATE) |=> rd_data_o == {4'h0, $past(state_q)};
  endproperty
  a_state_nibble: assert property (p_state_nibble)
    else $error("state register read is wrong");

  property p_code_legal;
    @(posedge clk_sys_i) disable iff (rst_i) state_q <= ST_MAIN_ERR;
  endproperty
  a_code_legal: assert property (p_code_legal)
    else $error("state code out of range");

  property p_transit;
    @(posedge clk_sys_i) disable iff (rst_i)
      (state_q == ST_BIAS_INIT || state_q == ST_BIAS_ADDR ||
       state_q == ST_BIAS_FREQ || state_q == ST_MAIN_EN) |=> state_q != $past(state_q);
  endproperty
  a_transit: assert property (p_transit)
    else $error("transit state dwelt");

  property p_clear_resolved;
    @(posedge clk_sys_i) disable iff (rst_i)
      s_read(ADDR_CAUSE1) ##1 1'b1 |-> (cause1_q & ~prot_pin_q) == 8'h00;
  endproperty
  a_clear_resolved: assert property (p_clear_resolved)
    else $error("resolved cause bit survived a read");

  property p_keep_present;
    @(posedge clk_sys_i) disable iff (rst_i)
      1'b1 |=> (cause1_q & prot_pin_q) == prot_pin_q;
  endproperty
  a_keep_present: assert property (p_keep_present)
    else $error("present cause bit not set");

  property p_cccv;
    @(posedge clk_sys_i) disable iff (rst_i)
      $changed(prot_i.cc_mode) |=> cause1_q[C1_CCCV_BIT];
  endproperty
  a_cccv: assert property (p_cccv)
    else $error("mode change not recorded");

  property p_unused_zero;
    @(posedge clk_sys_i) disable iff (rst_i)
      (cause1_q & ~CAUSE1_USED) == 8'h00 && (cause2_q & ~CAUSE2_USED) == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused cause bit set");

  property p_load_reads_zero;
    @(posedge clk_sys_i) disable iff (rst_i)
      s_read(ADDR_CMD) |=> rd_data_o[CMD_LOAD_VOUT_BIT] == 1'b0;
  endproperty
  a_load_reads_zero: assert property (p_load_reads_zero)
    else $error("load bit read back as one");

  property p_vout_load;
    @(posedge clk_sys_i) disable iff (rst_i)
      load_vout |=> vout_q == {$past(cfg[ADDR_VOUT_HI - ADDR_MASK1]),
                               $past(cfg[ADDR_VOUT_LO - ADDR_MASK1][VOUT_LO_MSB:VOUT_LO_LSB])};
  endproperty
  a_vout_load: assert property (p_vout_load)
    else $error("voltage code not loaded");

  property p_masked_quiet;
    @(posedge clk_sys_i) disable iff (rst_i)
      ((cause1_q & ~mask1_eff) == 8'h00 && (cause2_q & ~mask2_eff) == 8'h00) |=> !irq_o;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("masked cause raised the interrupt");

  property p_mask_all;
    @(posedge clk_sys_i) disable iff (rst_i)
      config_byte_1_o[CFG1_MASK_ALL_BIT] [*2] |-> !irq_o;
  endproperty
  a_mask_all: assert property (p_mask_all)
    else $error("interrupt while mask-all set");

  property p_reserved_zero;
    @(posedge clk_sys_i) disable iff (rst_i)
      s_read(ADDR_RSVD) |=> rd_data_o == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved register read nonzero");

endmodule : chgrm_regbank

// File: test/charger_i2c_register_map_bench.sv
// Self-checking bench for the register bank.
module charger_i2c_register_map_bench
  import chgrm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // Expected bytes after reset and after writing all ones everywhere.
  localparam logic [7:0] RST_TBL [16] = '{8'h00, 8'h00, 8'h00, 8'hfc, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h28, 8'hf3, 8'h32, 8'h10, 8'hff, 8'h30, 8'h23, 8'h9e};
  localparam logic [7:0] WR_TBL [16] = '{8'h00, 8'h00, 8'h00, 8'hfc, 8'h00, 8'h01, 8'hbd,
    8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff};
  // Cause byte one bits and the protection input that sets each.
  localparam int C1_BIT [6] = '{7, 5, 4, 3, 2, 0};
  localparam int PROT_BIT [6] = '{12, 11, 10, 9, 8, 7};

  logic clk_sys_i = 1'b0;
  logic rst_i;
  chgrm_req_t req;
  chgrm_cond_t cond;
  chgrm_prot_t prot;
  logic [7:0] status_flags;
  logic [7:0] rd_data;
  logic irq;
  logic main_enable;
  logic [3:0] state;
  logic [VOUT_WIDTH-1:0] vout_code;
  logic [7:0] current_limit_code_code;
  logic [AUX_WIDTH-1:0] aux_code;
  logic [7:0] cfg1, cfg2, cfg4, cfg5;
  logic [7:0] v;
  int bad_count = 0;
  int compares = 0;

  // The clock toggles every half period of 10 ns.
  always #5 clk_sys_i = ~clk_sys_i;

  // Short retry wait keeps the error position from stalling the run.
  chgrm_regbank #(.ERR_WAIT(8)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req), .rd_data_o(rd_data),
    .cond_i(cond), .prot_i(prot), .status_flags_i(status_flags), .irq_o(irq),
    .main_enable_o(main_enable), .state_o(state), .output_voltage_code_o(vout_code),
    .current_limit_code_o(current_limit_code_code), .aux_regulator_voltage_o(aux_code),
    .config_byte_1_o(cfg1), .config_byte_2_o(cfg2), .config_byte_4_o(cfg4),
    .config_byte_5_o(cfg5));

  chgrm_host_model host (.clk_sys_i(clk_sys_i), .rd_data_i(rd_data), .req_o(req));

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Compares one value; a mismatch is counted and reported.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic settle();
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask : settle

  task automatic do_reset();
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
  endtask : do_reset

  // One-cycle pulse of a protection input, then time for the interrupt to rise.
  task automatic pulse(input int pb);
    @(posedge clk_sys_i);
    prot <= chgrm_prot_t'(13'h1 << pb);
    @(posedge clk_sys_i);
    prot <= '0;
    settle();
  endtask : pulse

  task automatic t_reset_values();
    for (int a = 0; a < 16; a++) begin
      host.read_reg(4'(a), a % 2, v);
      chk($sformatf("reset byte %0h", a), 16'(RST_TBL[a]), 16'(v));
    end
    chk("vout after reset", 16'h0190, 16'(vout_code));
    chk("irq after reset", 16'h0000, 16'(irq));
  endtask : t_reset_values

  task automatic t_write_all();
    for (int a = 0; a < 16; a++) begin
      host.write_reg(4'(a), 8'hff);
    end
    for (int a = 0; a < 16; a++) begin
      host.read_reg(4'(a), 0, v);
      chk($sformatf("written byte %0h", a), 16'(WR_TBL[a]), 16'(v));
    end
    chk("current_limit_code out", 16'h00ff, 16'(current_limit_code_code));
    chk("aux out", 16'h003f, 16'(aux_code));
    chk("cfg outs", 16'hffff, {cfg1 & cfg2, cfg4 & cfg5});
    chk("main enable", 16'h0001, 16'(main_enable));
    chk("vout before load", 16'h0190, 16'(vout_code));
    host.write_reg(ADDR_CMD, 8'h03);
    settle();
    chk("vout loaded", 16'h07ff, 16'(vout_code));
  endtask : t_write_all

  task automatic t_voltage();
    do_reset();
    host.write_reg(ADDR_VOUT_HI, 8'hab);
    host.write_reg(ADDR_VOUT_LO, 8'he0);
    settle();
    chk("vout unloaded", 16'h0190, 16'(vout_code));
    host.write_reg(ADDR_CMD, 8'h02);
    settle();
    chk("vout split", 16'h055f, 16'(vout_code));
    chk("main disabled", 16'h0000, 16'(main_enable));
    host.read_reg(ADDR_CMD, 0, v);
    chk("load bit reads zero", 16'h0000, 16'(v));
  endtask : t_voltage

  task automatic t_cause1();
    host.write_reg(ADDR_CFG1, 8'h08);
    for (int i = 0; i < 6; i++) begin
      pulse(PROT_BIT[i]);
      chk("irq raised", 16'h0001, 16'(irq));
      host.read_reg(ADDR_CAUSE1, 0, v);
      chk("cause1 bit", 16'h1 << C1_BIT[i], 16'(v));
      host.read_reg(ADDR_CAUSE1, 1, v);
      chk("cause1 cleared", 16'h0000, 16'(v));
      settle();
      chk("irq released", 16'h0000, 16'(irq));
    end
  endtask : t_cause1

  task automatic t_persist();
    @(posedge clk_sys_i);
    prot <= chgrm_prot_t'(13'h1 << 8);
    settle();
    host.read_reg(ADDR_CAUSE1, 0, v);
    chk("soft thermal set", 16'h0004, 16'(v));
    host.read_reg(ADDR_CAUSE1, 0, v);
    chk("present cause kept", 16'h0004, 16'(v));
    @(posedge clk_sys_i);
    prot <= '0;
    host.read_reg(ADDR_CAUSE1, 1, v);
    chk("resolved cause read", 16'h0004, 16'(v));
    host.read_reg(ADDR_CAUSE1, 0, v);
    chk("resolved cause cleared", 16'h0000, 16'(v));
  endtask : t_persist

  task automatic t_masks();
    host.write_reg(ADDR_MASK1, 8'h08);
    pulse(9);
    chk("masked hard thermal", 16'h0000, 16'(irq));
    host.read_reg(ADDR_CAUSE1, 0, v);
    chk("masked cause kept", 16'h0008, 16'(v));
    host.write_reg(ADDR_MASK2, 8'h20);
    pulse(5);
    chk("masked overvoltage", 16'h0000, 16'(irq));
    host.read_reg(ADDR_CAUSE2, 0, v);
    chk("cause2 overvoltage", 16'h0020, 16'(v));
    pulse(6);
    chk("unmasked overcurrent", 16'h0001, 16'(irq));
    host.read_reg(ADDR_CAUSE2, 0, v);
    chk("cause2 overcurrent", 16'h0040, 16'(v));
    host.write_reg(ADDR_MASK1, 8'h00);
    pulse(10);
    chk("freq resistor irq", 16'h0001, 16'(irq));
    host.write_reg(ADDR_CFG1, 8'h28);
    settle();
    chk("mask all drops irq", 16'h0000, 16'(irq));
    host.read_reg(ADDR_CAUSE1, 0, v);
    chk("cause under mask all", 16'h0010, 16'(v));
  endtask : t_masks

  // Waits, then reads the position byte and checks it and the state port.
  task automatic chk_state(input int wait_cycles, input logic [3:0] exp);
    repeat (wait_cycles) @(posedge clk_sys_i);
    host.read_reg(ADDR_STATE, 0, v);
    chk("state byte", 16'(exp), 16'(v));
    chk("state port", 16'(exp), 16'(state));
  endtask : chk_state

  // Walks the sequencer through ready, on, error, retry and shutdown.
  task automatic t_state();
    @(posedge clk_sys_i);
    cond <= '{power_input_supply_ok: 1'b1, bias_good: 1'b1, bias_fault: 1'b0, freq_res_ok: 1'b1,
      main_pg: 1'b1, main_off: 1'b0, main_fault: 1'b0};
    chk_state(60, ST_BIAS_READY);
    host.write_reg(ADDR_CMD, 8'h01);
    chk_state(8, ST_MAIN_ON);
    @(posedge clk_sys_i);
    cond.main_fault <= 1'b1;
    chk_state(0, ST_MAIN_ERR);
    @(posedge clk_sys_i);
    cond.main_fault <= 1'b0;
    chk_state(30, ST_MAIN_ON);
    host.write_reg(ADDR_CMD, 8'h00);
    chk_state(8, ST_MAIN_SHDN);
    @(posedge clk_sys_i);
    cond.main_off <= 1'b1;
    chk_state(8, ST_BIAS_READY);
  endtask : t_state

  // Main sequence.
  initial begin
    rst_i = 1'b1;
    cond = '0;
    prot = '0;
    status_flags = 8'hff;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_write_all();
    t_voltage();
    t_cause1();
    t_persist();
    t_masks();
    t_state();
    complete_run();
  end

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    complete_run();
  end
endmodule : charger_i2c_register_map_bench

// File: test/chgrm_host_model.sv
// Host side of the register port: issues one access at a time as the bank expects.
module chgrm_host_model
  import chgrm_pkg::*;
(
  // Clock.
  input wire logic clk_sys_i,
  // Register port towards the bank.
  input wire logic [7:0] rd_data_i,
  output chgrm_req_t req_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // The port is idle until the first access.
  initial begin
    req_o = '0;
  end

  // One write strobe, held for exactly one sampling edge.
  task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
    @(posedge clk_sys_i);
    req_o <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
    @(posedge clk_sys_i);
    req_o <= '0;
  endtask : write_reg

  // A read may start after idle cycles; data is taken the cycle after the strobe.
  task automatic read_reg(input logic [3:0] addr, input int gap, output logic [7:0] data);
    repeat (gap) @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    req_o <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
    @(posedge clk_sys_i);
    req_o <= '0;
    #1;
    data = rd_data_i;
  endtask : read_reg
endmodule : chgrm_host_model
